/* logic/dad_defs.svh */
// timing counts, field positions and reset values of the arithmetic datapath
// assumes inclusion by bare name from logic/ files only
`ifndef DAD_DEFS_SVH
`define DAD_DEFS_SVH

`define DAD_WORD_W 16
`define DAD_ACC_W 32
`define DAD_OP_W 5
`define DAD_SCALE_W 4
`define DAD_STORE_W 3
`define DAD_PM_W 2
`define DAD_BITSEL_W 4
`define DAD_HIGH_SHIFT 5'h10
`define DAD_SXM_POS 10
`define DAD_STATUS_RST 16'h0400
`define DAD_PM_RST 2'h0
`define DAD_PM_NONE 2'h0
`define DAD_PM_LEFT1 2'h1
`define DAD_PM_LEFT4 2'h2
`define DAD_PM_RIGHT6 2'h3
`define DAD_MAC_CYCLES 1

`endif

/* logic/dad_pkg.sv */
// types shared by the arithmetic datapath and its bench
// assumes dad_defs.svh sits beside it
`include "dad_defs.svh"
package dad_pkg;
   typedef enum logic [4:0] {
      DAD_OP_NOP = 5'h00,
      DAD_OP_LOAD = 5'h01,
      DAD_OP_ADD = 5'h02,
      DAD_OP_SUB = 5'h03,
      DAD_OP_ADD_HIGH = 5'h04,
      DAD_OP_AND = 5'h05,
      DAD_OP_OR = 5'h06,
      DAD_OP_XOR = 5'h07,
      DAD_OP_ADD_PROD = 5'h08,
      DAD_OP_SUB_PROD = 5'h09,
      DAD_OP_LOAD_LATCH = 5'h0A,
      DAD_OP_MULT = 5'h0B,
      DAD_OP_MAC = 5'h0C,
      DAD_OP_STORE_HIGH = 5'h0D,
      DAD_OP_STORE_LOW = 5'h0E,
      DAD_OP_BRANCH_ACC = 5'h0F,
      DAD_OP_NORMALIZE = 5'h10,
      DAD_OP_BIT_TEST = 5'h11,
      DAD_OP_LOAD_STATUS = 5'h12,
      DAD_OP_SET_PM = 5'h13,
      DAD_OP_ZERO = 5'h14
   } dad_op_t;
endpackage

/* logic/dad_mult_if.sv */
// signals between the datapath control and the multiplier
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface dad_mult_if;
   logic latch_load;
   logic [15:0] latch_value;
   logic mul_go;
   logic [15:0] mul_a;
   logic [15:0] mul_b;
   logic [15:0] latch;
   logic [31:0] product;
   modport ctrl (output latch_load, latch_value, mul_go, mul_a, mul_b,
      input latch, product);
   modport mult (input latch_load, latch_value, mul_go, mul_a, mul_b,
      output latch, product);
endinterface

/* logic/dad_mult.sv */
// signed 16x16 multiplier with operand latch and product holder
// assumes the control end raises mul_go for one cycle per product
`timescale 1ns/1ns
`include "dad_defs.svh"
module dad_mult (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   dad_mult_if.mult mif
);
   logic [15:0] multiplier_operand_latch;
   logic [31:0] multiplier_result_holder;
   logic [15:0] next_latch;
   logic [31:0] next_result;

   always_comb begin
      next_latch = multiplier_operand_latch;
      next_result = multiplier_result_holder;
      if (mif.latch_load) begin
         next_latch = mif.latch_value;
      end
      if (mif.mul_go) begin
         next_result = 32'($signed(mif.mul_a) * $signed(mif.mul_b));
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         multiplier_operand_latch <= 16'h0000;
         multiplier_result_holder <= 32'h0000_0000;
      end else begin
         multiplier_operand_latch <= next_latch;
         multiplier_result_holder <= next_result;
      end
   end

   assign mif.latch = multiplier_operand_latch;
   assign mif.product = multiplier_result_holder;

   mult_product_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      mif.mul_go |=> multiplier_result_holder ==
      32'($signed($past(mif.mul_a)) * $signed($past(mif.mul_b))))
      else $error("product holder wrong after multiply");
   latch_hold_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      !mif.latch_load |=> $stable(multiplier_operand_latch))
      else $error("operand latch changed without load");
endmodule

/* logic/dad_datapath.sv */
// arithmetic datapath: scaling shifter, alu, accumulator, store shifters
// assumes decoder and data bus on the same clock; one op per valid cycle
// How it works
// - shifter takes 16 bits, gives 32, shift 0-16
// - zero fill low, sign or zero fill high
// - alu operands: accumulator plus product or shifter
// - alu result written back to accumulator
// - accumulator stored as two 16-bit halves
// - store shift leaves accumulator untouched
// - branch target taken from accumulator
// - normalize the accumulator value
// - test one data word bit for branching
// - full signed 32-bit product in one cycle
// - 16-bit operand latch, 32-bit product holder
// - product output passes four-mode shifter
// - mac takes both operands each cycle
// - 2-bit field selects product shift
// - 4-bit instruction code sets scaling shift
`timescale 1ns/1ns
`include "dad_defs.svh"
module dad_datapath (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic op_valid_in,
   input wire dad_pkg::dad_op_t op_code_in,
   input wire logic [3:0] scale_shift_in,
   input wire logic [2:0] store_shift_in,
   input wire logic [1:0] pm_value_in,
   input wire logic [3:0] bit_select_in,
   input wire logic [15:0] data_in,
   input wire logic [15:0] prog_in,
   output logic [31:0] acc_out,
   output logic [15:0] data_out,
   output logic data_oe_out,
   output logic branch_out,
   output logic [15:0] branch_addr_out,
   output logic test_flag_out,
   output logic [15:0] status_out,
   output logic [1:0] pm_out,
   output logic [15:0] operand_latch_out,
   output logic [31:0] product_out
);
   dad_mult_if mif ();

   dad_mult u_mult (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .mif(mif.mult)
   );

   logic [31:0] acc;
   logic [15:0] status_word_zero;
   logic [1:0] product_shift_code_field;
   logic [15:0] store_data;
   logic store_oe;
   logic branch;
   logic [15:0] branch_addr;
   logic test_flag;
   logic [31:0] next_acc;
   logic [15:0] next_status;
   logic [1:0] next_pm;
   logic [15:0] next_store_data;
   logic next_store_oe;
   logic next_branch;
   logic [15:0] next_branch_addr;
   logic next_test_flag;

   logic sign_extension_select;
   logic [4:0] shift_amt;
   logic [31:0] extended;
   logic [31:0] scaled;
   logic [31:0] shifted_product;
   logic [31:0] store_shifted;
   logic [31:0] alu_b;
   logic use_product;
   dad_pkg::dad_op_t op;

   assign op = op_valid_in ? op_code_in : dad_pkg::DAD_OP_NOP;
   assign sign_extension_select = status_word_zero[`DAD_SXM_POS];

   // scaling shifter
   always_comb begin
      shift_amt = {1'b0, scale_shift_in};
      if (op == dad_pkg::DAD_OP_ADD_HIGH) begin
         shift_amt = `DAD_HIGH_SHIFT;
      end
      if (sign_extension_select) begin
         extended = {{16{data_in[15]}}, data_in};
      end else begin
         extended = {16'h0000, data_in};
      end
      scaled = extended << shift_amt;
   end

   // product output shifter
   always_comb begin
      case (product_shift_code_field)
         `DAD_PM_NONE: shifted_product = mif.product;
         `DAD_PM_LEFT1: shifted_product = {mif.product[30:0], 1'b0};
         `DAD_PM_LEFT4: shifted_product = {mif.product[27:0], 4'h0};
         `DAD_PM_RIGHT6: begin
            shifted_product = {{6{mif.product[31]}}, mif.product[31:6]};
         end
         default: shifted_product = mif.product;
      endcase
   end

   assign store_shifted = acc << store_shift_in;
   assign use_product = (op == dad_pkg::DAD_OP_ADD_PROD) ||
      (op == dad_pkg::DAD_OP_SUB_PROD) || (op == dad_pkg::DAD_OP_MAC);
   assign alu_b = use_product ? shifted_product : scaled;

   // multiplier control
   always_comb begin
      mif.latch_load = 1'b0;
      mif.latch_value = data_in;
      mif.mul_go = 1'b0;
      mif.mul_a = mif.latch;
      mif.mul_b = data_in;
      case (op)
         dad_pkg::DAD_OP_LOAD_LATCH: mif.latch_load = 1'b1;
         dad_pkg::DAD_OP_MULT: mif.mul_go = 1'b1;
         dad_pkg::DAD_OP_MAC: begin
            mif.latch_load = 1'b1;
            mif.mul_go = 1'b1;
            mif.mul_a = prog_in;
         end
         default: mif.mul_go = 1'b0;
      endcase
   end

   // alu, accumulator and store path
   always_comb begin
      next_acc = acc;
      next_status = status_word_zero;
      next_pm = product_shift_code_field;
      next_store_data = store_data;
      next_store_oe = 1'b0;
      next_branch = 1'b0;
      next_branch_addr = branch_addr;
      next_test_flag = test_flag;
      case (op)
         dad_pkg::DAD_OP_LOAD: next_acc = alu_b;
         dad_pkg::DAD_OP_ADD: next_acc = acc + alu_b;
         dad_pkg::DAD_OP_ADD_HIGH: next_acc = acc + alu_b;
         dad_pkg::DAD_OP_SUB: next_acc = acc - alu_b;
         dad_pkg::DAD_OP_AND: next_acc = acc & alu_b;
         dad_pkg::DAD_OP_OR: next_acc = acc | alu_b;
         dad_pkg::DAD_OP_XOR: next_acc = acc ^ alu_b;
         dad_pkg::DAD_OP_ADD_PROD: next_acc = acc + alu_b;
         dad_pkg::DAD_OP_SUB_PROD: next_acc = acc - alu_b;
         dad_pkg::DAD_OP_MAC: next_acc = acc + alu_b;
         dad_pkg::DAD_OP_ZERO: next_acc = 32'h0000_0000;
         dad_pkg::DAD_OP_STORE_HIGH: begin
            next_store_data = store_shifted[31:16];
            next_store_oe = 1'b1;
         end
         dad_pkg::DAD_OP_STORE_LOW: begin
            next_store_data = store_shifted[15:0];
            next_store_oe = 1'b1;
         end
         dad_pkg::DAD_OP_BRANCH_ACC: begin
            next_branch = 1'b1;
            next_branch_addr = acc[15:0];
         end
         dad_pkg::DAD_OP_NORMALIZE: begin
            // one step per op; flag high once the top two bits differ or the accumulator is zero
            if ((acc[31] != acc[30]) || (acc == 32'h0000_0000)) begin
               next_test_flag = 1'b1;
            end else begin
               next_acc = {acc[30:0], 1'b0};
               next_test_flag = 1'b0;
            end
         end
         dad_pkg::DAD_OP_BIT_TEST: begin
            // bit code 0 selects the word's most significant bit
            next_test_flag = data_in[4'hF - bit_select_in];
         end
         dad_pkg::DAD_OP_LOAD_STATUS: next_status = data_in;
         dad_pkg::DAD_OP_SET_PM: next_pm = pm_value_in;
         default: next_acc = acc;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc <= 32'h0000_0000;
         status_word_zero <= `DAD_STATUS_RST;
         product_shift_code_field <= `DAD_PM_RST;
         store_data <= 16'h0000;
         store_oe <= 1'b0;
         branch <= 1'b0;
         branch_addr <= 16'h0000;
         test_flag <= 1'b0;
      end else begin
         acc <= next_acc;
         status_word_zero <= next_status;
         product_shift_code_field <= next_pm;
         store_data <= next_store_data;
         store_oe <= next_store_oe;
         branch <= next_branch;
         branch_addr <= next_branch_addr;
         test_flag <= next_test_flag;
      end
   end

   assign acc_out = acc;
   assign data_out = store_data;
   assign data_oe_out = store_oe;
   assign branch_out = branch;
   assign branch_addr_out = branch_addr;
   assign test_flag_out = test_flag;
   assign status_out = status_word_zero;
   assign pm_out = product_shift_code_field;
   assign operand_latch_out = mif.latch;
   assign product_out = mif.product;

   scale_load_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_LOAD) |=> acc == $past(scaled))
      else $error("load did not place scaled word");
   high_add_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_ADD_HIGH)
      |=> acc == $past(acc) + {$past(data_in), 16'h0000})
      else $error("high add did not shift by sixteen");
   zero_fill_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_LOAD && !sign_extension_select)
      |=> acc == ({16'h0000, $past(data_in)} << $past(scale_shift_in)))
      else $error("high bits not zero filled");
   sign_fill_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_LOAD && sign_extension_select)
      |=> acc == (32'($signed($past(data_in))) << $past(scale_shift_in)))
      else $error("high bits not sign filled");
   alu_add_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_ADD) |=> acc == $past(acc) + $past(scaled))
      else $error("add result not in accumulator");
   alu_sub_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_SUB) |=> acc == $past(acc) - $past(scaled))
      else $error("subtract result not in accumulator");
   alu_and_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_AND) |=> acc == ($past(acc) & $past(scaled)))
      else $error("and result not in accumulator");
   alu_xor_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_XOR) |=> acc == ($past(acc) ^ $past(scaled)))
      else $error("xor result not in accumulator");
   prod_add_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_ADD_PROD)
      |=> acc == $past(acc) + $past(shifted_product))
      else $error("product add wrong");
   prod_sub_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_SUB_PROD)
      |=> acc == $past(acc) - $past(shifted_product))
      else $error("product subtract wrong");
   pm_right_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (product_shift_code_field == `DAD_PM_RIGHT6)
      |-> $signed(shifted_product) == ($signed(mif.product) >>> 6))
      else $error("right shift of product wrong");
   pm_set_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_SET_PM) |=> pm_out == $past(pm_value_in))
      else $error("product shift code not loaded");
   store_keep_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_STORE_HIGH)
      |=> data_oe_out && $stable(acc)
      && data_out == $past(store_shifted[31:16]))
      else $error("high store wrong or accumulator changed");
   store_low_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_STORE_LOW)
      |=> data_oe_out && data_out == $past(store_shifted[15:0]))
      else $error("low store wrong");
   store_pulse_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      !(op == dad_pkg::DAD_OP_STORE_HIGH || op == dad_pkg::DAD_OP_STORE_LOW)
      |=> !data_oe_out)
      else $error("store enable without store");
   branch_acc_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_BRANCH_ACC)
      |=> branch_out && branch_addr_out == $past(acc[15:0])
      ##1 branch_out == $past(op == dad_pkg::DAD_OP_BRANCH_ACC))
      else $error("branch target not from accumulator");
   bit_test_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_BIT_TEST)
      |=> test_flag_out == $past(data_in[4'hF - bit_select_in]))
      else $error("bit test flag wrong");
   mult_latch_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_LOAD_LATCH)
      |=> operand_latch_out == $past(data_in))
      else $error("operand latch not loaded");
   mult_use_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_MULT) |=> product_out ==
      32'($signed($past(operand_latch_out)) * $signed($past(data_in))))
      else $error("multiply did not use operand latch");
   mac_pair_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_MAC) |=> operand_latch_out == $past(data_in)
      && product_out == 32'($signed($past(prog_in))
      * $signed($past(data_in))))
      else $error("mac operands not taken together");
   norm_step_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_NORMALIZE && acc[31] == acc[30]
      && acc != 32'h0000_0000) |=> acc == {$past(acc[30:0]), 1'b0}
      && !test_flag_out)
      else $error("normalize step wrong");
   norm_done_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (op == dad_pkg::DAD_OP_NORMALIZE && (acc[31] != acc[30]
      || acc == 32'h0000_0000)) |=> $stable(acc) && test_flag_out)
      else $error("normalize did not stop");
   refused_hold_a: assert property (
      @(posedge ref_clk_in) disable iff (!nrst_in)
      !op_valid_in |=> $stable(acc) && $stable(status_out)
      && $stable(pm_out) && $stable(operand_latch_out)
      && $stable(product_out) && !data_oe_out && !branch_out)
      else $error("idle cycle changed state");
endmodule

/* dv/tb_top.sv */
// self-checking bench for the arithmetic datapath, reference model inside
// assumes the datapath package and defines are compiled first
`timescale 1ns/1ns
module tb_top;
   logic clk;
   logic nrst;
   logic valid;
   dad_pkg::dad_op_t op;
   logic [3:0] sc;
   logic [3:0] bs;
   logic [2:0] xs;
   logic [1:0] pmv;
   logic [15:0] din;
   logic [15:0] pin;
   logic [31:0] acc_o;
   logic [31:0] prod_o;
   logic [15:0] dout_o;
   logic [15:0] baddr_o;
   logic [15:0] stat_o;
   logic [15:0] latch_o;
   logic oe_o;
   logic br_o;
   logic flag_o;
   logic [1:0] pm_o;
   logic [31:0] e_acc;
   logic [31:0] e_prod;
   logic [15:0] e_dout;
   logic [15:0] e_baddr;
   logic [15:0] e_stat;
   logic [15:0] e_latch;
   logic e_oe;
   logic e_br;
   logic e_flag;
   logic [1:0] e_pm;
   int mismatches;
   int checked;

   dad_datapath uut (.ref_clk_in(clk), .nrst_in(nrst), .op_valid_in(valid),
      .op_code_in(op), .scale_shift_in(sc), .store_shift_in(xs),
      .pm_value_in(pmv), .bit_select_in(bs), .data_in(din), .prog_in(pin),
      .acc_out(acc_o), .data_out(dout_o), .data_oe_out(oe_o),
      .branch_out(br_o), .branch_addr_out(baddr_o), .test_flag_out(flag_o),
      .status_out(stat_o), .pm_out(pm_o), .operand_latch_out(latch_o),
      .product_out(prod_o));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] scaled(input logic [15:0] d,
      input logic [4:0] s, input logic sx);
      logic [31:0] w;
      w = sx ? {{16{d[15]}}, d} : {16'h0000, d};
      return w << s;
   endfunction

   function automatic logic [31:0] pshift(input logic [31:0] p,
      input logic [1:0] m);
      case (m)
         2'h1: return p << 1;
         2'h2: return p << 4;
         2'h3: return $signed(p) >>> 6;
         default: return p;
      endcase
   endfunction

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_all;
      chk_word(acc_o, e_acc);
      chk_word({16'h0000, dout_o}, {16'h0000, e_dout});
      chk_bit(oe_o, e_oe);
      chk_bit(br_o, e_br);
      chk_word({16'h0000, baddr_o}, {16'h0000, e_baddr});
      chk_bit(flag_o, e_flag);
      chk_word({16'h0000, stat_o}, {16'h0000, e_stat});
      chk_word({30'h0, pm_o}, {30'h0, e_pm});
      chk_word({16'h0000, latch_o}, {16'h0000, e_latch});
      chk_word(prod_o, e_prod);
   endtask

   task automatic step(input logic v, input logic [4:0] o,
      input logic [15:0] d, input logic [15:0] p, input logic [3:0] s,
      input logic [2:0] x, input logic [1:0] m, input logic [3:0] b);
      logic [31:0] sh;
      logic [31:0] pv;
      logic [31:0] sv;
      @(negedge clk);
      check_all;
      valid = v;
      op = dad_pkg::dad_op_t'(o);
      din = d;
      pin = p;
      sc = s;
      xs = x;
      pmv = m;
      bs = b;
      e_oe = 1'b0;
      e_br = 1'b0;
      sh = e_acc << x;
      pv = pshift(e_prod, e_pm);
      sv = scaled(d, {1'b0, s}, e_stat[10]);
      if (v) begin
         case (o)
            dad_pkg::DAD_OP_LOAD: e_acc = sv;
            dad_pkg::DAD_OP_ADD: e_acc = e_acc + sv;
            dad_pkg::DAD_OP_SUB: e_acc = e_acc - sv;
            dad_pkg::DAD_OP_ADD_HIGH: e_acc = e_acc + scaled(d, 5'h10, 1'b0);
            dad_pkg::DAD_OP_AND: e_acc = e_acc & sv;
            dad_pkg::DAD_OP_OR: e_acc = e_acc | sv;
            dad_pkg::DAD_OP_XOR: e_acc = e_acc ^ sv;
            dad_pkg::DAD_OP_ADD_PROD: e_acc = e_acc + pv;
            dad_pkg::DAD_OP_SUB_PROD: e_acc = e_acc - pv;
            dad_pkg::DAD_OP_LOAD_LATCH: e_latch = d;
            dad_pkg::DAD_OP_MULT: e_prod = $signed(e_latch) * $signed(d);
            dad_pkg::DAD_OP_MAC: begin
               e_prod = $signed(p) * $signed(d);
               e_latch = d;
               e_acc = e_acc + pv;
            end
            dad_pkg::DAD_OP_STORE_HIGH: begin
               e_dout = sh[31:16];
               e_oe = 1'b1;
            end
            dad_pkg::DAD_OP_STORE_LOW: begin
               e_dout = sh[15:0];
               e_oe = 1'b1;
            end
            dad_pkg::DAD_OP_BRANCH_ACC: begin
               e_br = 1'b1;
               e_baddr = e_acc[15:0];
            end
            dad_pkg::DAD_OP_NORMALIZE: begin
               e_flag = (e_acc[31] != e_acc[30]) || (e_acc == 32'h00000000);
               if (!e_flag) begin
                  e_acc = e_acc << 1;
               end
            end
            dad_pkg::DAD_OP_BIT_TEST: e_flag = d[4'hF - b];
            dad_pkg::DAD_OP_LOAD_STATUS: e_stat = d;
            dad_pkg::DAD_OP_SET_PM: e_pm = m;
            dad_pkg::DAD_OP_ZERO: e_acc = 32'h00000000;
            default: ;
         endcase
      end
   endtask

   task automatic results;
      if (mismatches == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results;
   end

   initial begin
      mismatches = 0;
      checked = 0;
      nrst = 1'b0;
      valid = 1'b0;
      op = dad_pkg::DAD_OP_NOP;
      {sc, bs, xs, pmv, din, pin} = '0;
      {e_acc, e_prod, e_dout, e_baddr, e_latch} = '0;
      {e_oe, e_br, e_flag, e_pm} = '0;
      e_stat = 16'h0400;
      void'($urandom(32'hAE078586));
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      // corner cases: sign fill, full shift, product modes, pulses
      step(1, dad_pkg::DAD_OP_LOAD, 16'h8001, 0, 4'h4, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_LOAD_STATUS, 16'h0000, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_SUB, 16'h8001, 0, 4'hF, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_ADD_HIGH, 16'hFFFF, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_LOAD_LATCH, 16'h8000, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_MULT, 16'h8000, 0, 0, 0, 0, 0);
      for (int m = 0; m < 4; m++) begin
         step(1, dad_pkg::DAD_OP_SET_PM, 0, 0, 0, 0, 2'(m), 0);
         step(1, dad_pkg::DAD_OP_ADD_PROD, 0, 0, 0, 0, 0, 0);
         step(1, dad_pkg::DAD_OP_MAC, 16'hFFFD, 16'h7FFF, 0, 0, 0, 0);
         step(1, dad_pkg::DAD_OP_MAC, 16'h8000, 16'h8000, 0, 0, 0, 0);
         step(1, dad_pkg::DAD_OP_SUB_PROD, 0, 0, 0, 0, 0, 0);
      end
      step(1, dad_pkg::DAD_OP_STORE_HIGH, 0, 0, 0, 3'h7, 0, 0);
      step(1, dad_pkg::DAD_OP_STORE_LOW, 0, 0, 0, 3'h7, 0, 0);
      step(1, dad_pkg::DAD_OP_BRANCH_ACC, 0, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_BRANCH_ACC, 0, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_ZERO, 0, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_NORMALIZE, 0, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_LOAD, 16'h0003, 0, 0, 0, 0, 0);
      repeat (3) step(1, dad_pkg::DAD_OP_NORMALIZE, 0, 0, 0, 0, 0, 0);
      step(1, dad_pkg::DAD_OP_BIT_TEST, 16'h8000, 0, 0, 0, 0, 4'h0);
      step(1, dad_pkg::DAD_OP_BIT_TEST, 16'h0001, 0, 0, 0, 0, 4'hF);
      step(0, dad_pkg::DAD_OP_ZERO, 0, 0, 0, 0, 0, 0);
      step(1, 5'h1F, 16'hFFFF, 0, 0, 0, 0, 0);
      for (int i = 0; i < 1500; i++) begin
         step($urandom_range(7, 0) != 0, 5'($urandom_range(23, 0)),
            16'($urandom), 16'($urandom), 4'($urandom), 3'($urandom),
            2'($urandom), 4'($urandom));
      end
      step(0, dad_pkg::DAD_OP_NOP, 0, 0, 0, 0, 0, 0);
      results;
   end
endmodule
